// ===== hw/rdw_pkg.sv
// constants, register map and types for the reset delay and watchdog block
`default_nettype none
package rdw_pkg;
	localparam int RDW_CLK_MHZ = 100;
	// delay and watchdog times as specified, in microseconds; the short delay in nanoseconds
	localparam int RDW_DRT_LONG_US = 18000;
	localparam int RDW_DRT_POR_US = 1000;
	localparam int RDW_DRT_SHORT_NS = 10000;
	localparam int RDW_WDT_BASE_US = 18000;
	localparam int RDW_DRT_LONG_CYC = RDW_DRT_LONG_US * RDW_CLK_MHZ;
	localparam int RDW_DRT_POR_CYC = RDW_DRT_POR_US * RDW_CLK_MHZ;
	localparam int RDW_DRT_SHORT_CYC = RDW_DRT_SHORT_NS * RDW_CLK_MHZ / 1000;
	localparam int RDW_WDT_BASE_CYC = RDW_WDT_BASE_US * RDW_CLK_MHZ;
	localparam int RDW_CNT_W = 24;

	// register byte offsets
	localparam logic [7:0] RDW_OFS_OPTION = 8'h00;
	localparam logic [7:0] RDW_OFS_CONFIG = 8'h04;
	localparam logic [7:0] RDW_OFS_STATUS = 8'h08;
	localparam logic [7:0] RDW_OFS_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] RDW_OFS_IRQ_MASK = 8'h10;

	// option register fields
	localparam int RDW_OPT_PSA_BIT = 3;
	localparam int RDW_OPT_RATE_LSB = 0;
	localparam logic [7:0] RDW_OPTION_RESET = 8'hff;

	// configuration register fields
	localparam int RDW_CFG_WATCHDOG_ENABLE_CFG_BIT = 0;
	localparam int RDW_CFG_PINEN_BIT = 1;
	localparam int RDW_CFG_OSC_LSB = 2;
	localparam logic [7:0] RDW_CONFIG_RESET = 8'h03;

	// status register fields
	localparam int RDW_ST_CORE_RST_BIT = 0;
	localparam int RDW_ST_DRT_BIT = 1;
	localparam int RDW_ST_SLEEP_BIT = 2;
	localparam int RDW_ST_PD_BIT = 3;
	localparam int RDW_ST_TO_BIT = 4;

	// interrupt events
	localparam int RDW_IRQ_W = 4;
	localparam int RDW_EV_WDT = 0;
	localparam int RDW_EV_RELEASE = 1;
	localparam int RDW_EV_PIN = 2;
	localparam int RDW_EV_POWER = 3;

	localparam logic [1:0] RDW_RESP_OKAY = 2'h0;
	localparam logic [1:0] RDW_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		RDW_OSC_INTERNAL = 2'b00,
		RDW_OSC_EXT_RC = 2'b01,
		RDW_OSC_LOW_POWER = 2'b10,
		RDW_OSC_CRYSTAL = 2'b11
	} rdw_osc_e;

	typedef enum logic [1:0] {
		RDW_DR_HOLD = 2'b00,
		RDW_DR_COUNT = 2'b01,
		RDW_DR_RUN = 2'b10
	} rdw_drt_e;
endpackage : rdw_pkg
`default_nettype wire

// ===== hw/rdw_sync.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module rdw_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic async_in, // pin level from outside
	output logic sync_out // filtered level
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sync_out <= RESET_VAL;
		else if (stage2 == stage3)
			sync_out <= stage3;
	end
endmodule // rdw_sync
`default_nettype wire

// ===== hw/rdw_watchdog.sv
// watchdog counter with optional power-of-two prescaler
`default_nettype none
module rdw_watchdog #(
	parameter int BASE_CYC = rdw_pkg::RDW_WDT_BASE_CYC
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic enable, // watchdog enable configuration
	input wire logic clear, // clear watchdog or sleep
	input wire logic assign_wdt, // prescaler belongs to the watchdog
	input wire logic [2:0] rate, // prescaler rate field
	output logic timeout // one-cycle timeout pulse
);
	import rdw_pkg::*;

	logic [RDW_CNT_W-1:0] base_cnt;
	logic [6:0] pre_cnt;
	logic base_wrap;
	logic [6:0] pre_last;

	assign base_wrap = (base_cnt == RDW_CNT_W'(BASE_CYC - 1));
	// divide by two to the power of the rate field
	assign pre_last = 7'((8'h01 << rate) - 8'h01);

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || clear)
			base_cnt <= '0;
		else if (base_wrap)
			base_cnt <= '0;
		else
			base_cnt <= base_cnt + 1'b1;
	end

	// prescaler is cleared by the clear input only when it is assigned here
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || (clear && assign_wdt))
			pre_cnt <= '0;
		else if (base_wrap && assign_wdt)
			pre_cnt <= (pre_cnt == pre_last) ? 7'h00 : pre_cnt + 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || clear)
			timeout <= 1'b0;
		else
			timeout <= base_wrap &&
				(!assign_wdt || pre_cnt == pre_last);
	end
endmodule // rdw_watchdog
`default_nettype wire

// ===== hw/rdw_top.sv
// reset latch, reset delay timer, watchdog and status registers
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`default_nettype none
module rdw_top #(
	parameter int DRT_LONG_CYC = rdw_pkg::RDW_DRT_LONG_CYC,
	parameter int DRT_POR_CYC = rdw_pkg::RDW_DRT_POR_CYC,
	parameter int WDT_BASE_CYC = rdw_pkg::RDW_WDT_BASE_CYC
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic power_good, // supply detector, async
	input wire logic external_reset_pin, // reset pin level, async
	input wire logic clear_watchdog_instr, // core pulse
	input wire logic sleep_instr, // core pulse
	input wire logic pin_change_wake, // wake-on-change pulse
	output logic core_reset, // core held in reset
	output logic timeout_flag_n, // timeout flag, active low
	output logic powerdown_flag_n, // power-down flag, active low
	output logic reset_pin_pullup_en, // weak pull-up on the pin
	output logic irq, // level interrupt
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	import rdw_pkg::*;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == RDW_OFS_OPTION) || (a == RDW_OFS_CONFIG) ||
			(a == RDW_OFS_STATUS) || (a == RDW_OFS_IRQ_STATUS) ||
			(a == RDW_OFS_IRQ_MASK);
	endfunction

	logic pwr_ok;
	logic pin_sync;
	logic pin_high;
	logic [7:0] option;
	logic [7:0] config_reg;
	logic [RDW_IRQ_W-1:0] irq_status;
	logic [RDW_IRQ_W-1:0] irq_mask;
	logic sleeping;
	logic por_pending;
	logic wdt_timeout;
	logic wdt_clear;
	rdw_drt_e drt_state;
	logic [RDW_CNT_W-1:0] drt_cnt;
	logic [RDW_CNT_W-1:0] drt_last;
	logic pin_reset;
	logic wdt_reset;
	logic wake_reset;
	logic reset_req;
	logic drt_done;
	rdw_osc_e osc_mode;
	logic [RDW_IRQ_W-1:0] events;

	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] status_byte;

	rdw_sync #(
		.RESET_VAL(1'b0)
	) u_pwr_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(power_good),
		.sync_out(pwr_ok)
	);

	rdw_sync #(
		.RESET_VAL(1'b0)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(external_reset_pin),
		.sync_out(pin_sync)
	);

	// pin disabled: internal reset tied to supply
	assign pin_high = pin_sync || !config_reg[RDW_CFG_PINEN_BIT];
	assign osc_mode = rdw_osc_e'(config_reg[RDW_CFG_OSC_LSB +: 2]);

	// keep the watchdog quiet while the core is in reset
	assign wdt_clear = clear_watchdog_instr || sleep_instr || core_reset;

	rdw_watchdog #(
		.BASE_CYC(WDT_BASE_CYC)
	) u_wdt (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(config_reg[RDW_CFG_WATCHDOG_ENABLE_CFG_BIT]),
		.clear(wdt_clear),
		.assign_wdt(option[RDW_OPT_PSA_BIT]),
		.rate(option[RDW_OPT_RATE_LSB +: 3]),
		.timeout(wdt_timeout)
	);

	// reset sources other than power loss
	assign pin_reset = config_reg[RDW_CFG_PINEN_BIT] && !pin_sync;
	assign wdt_reset = wdt_timeout && !core_reset;
	assign wake_reset = pin_change_wake && sleeping && !core_reset;
	assign reset_req = !pwr_ok || pin_reset || wdt_reset || wake_reset;

	// in the internal and external RC modes the first reset after power-up gets the power-on period
	always_comb begin
		unique case (osc_mode)
			RDW_OSC_INTERNAL, RDW_OSC_EXT_RC:
				drt_last = por_pending ?
					RDW_CNT_W'(DRT_POR_CYC - 1) :
					RDW_CNT_W'(RDW_DRT_SHORT_CYC - 1);
			RDW_OSC_LOW_POWER, RDW_OSC_CRYSTAL:
				drt_last = RDW_CNT_W'(DRT_LONG_CYC - 1);
		endcase
	end

	assign drt_done = (drt_state == RDW_DR_COUNT) && (drt_cnt == drt_last);

	// delay timer; aclk stands in for its internal oscillator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drt_state <= RDW_DR_HOLD;
			drt_cnt <= '0;
		end else if (!pwr_ok || pin_reset) begin
			drt_state <= RDW_DR_HOLD;
			drt_cnt <= '0;
		end else if (wdt_reset || wake_reset) begin
			drt_state <= RDW_DR_COUNT;
			drt_cnt <= '0;
		end else begin
			unique case (drt_state)
				RDW_DR_HOLD: begin
					if (pin_high)
						drt_state <= RDW_DR_COUNT;
					drt_cnt <= '0;
				end
				RDW_DR_COUNT: begin
					if (drt_done)
						drt_state <= RDW_DR_RUN;
					drt_cnt <= drt_cnt + 1'b1;
				end
				RDW_DR_RUN:
					drt_cnt <= '0;
				default: begin
					drt_state <= RDW_DR_HOLD;
					drt_cnt <= '0;
				end
			endcase
		end
	end

	// reset latch: set by any source, cleared only by delay expiry
	always_ff @(posedge aclk) begin
		if (!aresetn)
			core_reset <= 1'b1;
		else if (reset_req)
			core_reset <= 1'b1;
		else if (drt_done)
			core_reset <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !pwr_ok)
			por_pending <= 1'b1;
		else if (drt_done)
			por_pending <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || reset_req)
			sleeping <= 1'b0;
		else if (sleep_instr && !core_reset)
			sleeping <= 1'b1;
	end

	// timeout and power-down flags report the cause of the last reset, or the last sleep or watchdog clear since then
	always_ff @(posedge aclk) begin
		if (!aresetn || !pwr_ok) begin
			timeout_flag_n <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end else if (wdt_reset) begin
			timeout_flag_n <= 1'b0;
			if (sleeping)
				powerdown_flag_n <= 1'b0;
		end else if (wake_reset || (pin_reset && sleeping)) begin
			timeout_flag_n <= 1'b1;
			powerdown_flag_n <= 1'b0;
		end else if (sleep_instr && !core_reset) begin
			timeout_flag_n <= 1'b1;
			powerdown_flag_n <= 1'b0;
		end else if (clear_watchdog_instr && !core_reset) begin
			timeout_flag_n <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			reset_pin_pullup_en <= 1'b0;
		else
			reset_pin_pullup_en <= !config_reg[RDW_CFG_PINEN_BIT];
	end

	// write channel: address and data taken in either order
	// readies are flops mirroring the held flags, so no output is combinational
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			s_axi_awready <= 1'b1;
			aw_addr <= '0;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held <= 1'b1;
			s_axi_awready <= 1'b0;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			s_axi_wready <= 1'b1;
			w_data <= '0;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			s_axi_wready <= 1'b0;
			w_data <= s_axi_wdata;
			w_lane0 <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RDW_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_addr) ? RDW_RESP_OKAY :
				RDW_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// option is write-only and returns to all ones on every reset
	always_ff @(posedge aclk) begin
		if (!aresetn || reset_req)
			option <= RDW_OPTION_RESET;
		else if (wr_fire && w_lane0 && aw_addr == RDW_OFS_OPTION)
			option <= w_data[7:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			config_reg <= RDW_CONFIG_RESET;
		else if (wr_fire && w_lane0 && aw_addr == RDW_OFS_CONFIG)
			config_reg <= {4'h0, w_data[3:0]};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_mask <= '0;
		else if (wr_fire && w_lane0 && aw_addr == RDW_OFS_IRQ_MASK)
			irq_mask <= w_data[RDW_IRQ_W-1:0];
	end

	// read channel: one read at a time, answered the next cycle
	assign rd_fire = s_axi_arvalid && !s_axi_rvalid;

	assign status_byte = {3'h0, timeout_flag_n, powerdown_flag_n, sleeping,
		(drt_state == RDW_DR_COUNT), core_reset};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata <= '0;
			s_axi_rresp <= RDW_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? RDW_RESP_OKAY :
				RDW_RESP_SLVERR;
			unique case (s_axi_araddr)
				RDW_OFS_CONFIG:
					s_axi_rdata <= {24'h000000, config_reg};
				RDW_OFS_STATUS:
					s_axi_rdata <= {24'h000000, status_byte};
				RDW_OFS_IRQ_STATUS:
					s_axi_rdata <= {28'h0000000, irq_status};
				RDW_OFS_IRQ_MASK:
					s_axi_rdata <= {28'h0000000, irq_mask};
				default:
					s_axi_rdata <= '0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// sticky events; a new event beats the clearing read
	always_comb begin
		events = '0;
		events[RDW_EV_WDT] = wdt_reset;
		events[RDW_EV_RELEASE] = drt_done;
		events[RDW_EV_PIN] = pin_reset && !core_reset;
		events[RDW_EV_POWER] = !pwr_ok && !core_reset;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_status <= '0;
		else if (rd_fire && s_axi_araddr == RDW_OFS_IRQ_STATUS)
			irq_status <= events;
		else
			irq_status <= irq_status | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end
endmodule // rdw_top
`default_nettype wire

// ===== tb/rdw_top_assertions.sv
// checker properties for the reset delay and watchdog block
`default_nettype none
module rdw_top_assertions (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic power_good, // supply detector
	input wire logic clear_watchdog_instr, // core pulse
	input wire logic sleep_instr, // core pulse
	input wire logic core_reset, // core held in reset
	input wire logic timeout_flag_n, // timeout flag
	input wire logic powerdown_flag_n, // power-down flag
	input wire logic irq // level interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pwr_hold;
		!power_good [*8] |-> core_reset;
	endproperty
	property p_por_hold;
		$rose(aresetn) |-> core_reset [*8];
	endproperty
	// sync filter is short, so supply must be good 16 cycles before exit and at exit
	property p_release;
		$fell(core_reset) |-> $past(power_good, 16) && power_good;
	endproperty
	property p_wdog_reset;
		$fell(timeout_flag_n) |-> ##[0:2] core_reset;
	endproperty
	property p_clr_flags;
		clear_watchdog_instr && !core_reset |->
			##[1:2] (timeout_flag_n && powerdown_flag_n);
	endproperty
	property p_clr_quiet;
		clear_watchdog_instr && !core_reset |=>
			(!$fell(timeout_flag_n)) [*8];
	endproperty
	property p_sleep_flags;
		sleep_instr && !core_reset |->
			##[1:2] (!powerdown_flag_n && timeout_flag_n);
	endproperty
	property p_powerdown_keep;
		$fell(timeout_flag_n) |-> !$rose(powerdown_flag_n);
	endproperty
	a_pwr_hold: assert property (p_pwr_hold)
		else $error("core left reset without supply");
	a_por_hold: assert property (p_por_hold)
		else $error("core not held after power-up");
	a_release: assert property (p_release)
		else $error("core released too early");
	a_wdog_reset: assert property (p_wdog_reset)
		else $error("timeout flag without device reset");
	a_clr_flags: assert property (p_clr_flags)
		else $error("clear did not set both flags");
	a_clr_quiet: assert property (p_clr_quiet)
		else $error("timeout right after clear");
	a_sleep_flags: assert property (p_sleep_flags)
		else $error("sleep flags wrong");
	a_powerdown_keep: assert property (p_powerdown_keep)
		else $error("power-down flag rose on timeout");
	c_release: cover property ($fell(core_reset));
	c_timeout: cover property ($fell(timeout_flag_n));
	c_irq: cover property ($rose(irq));
endmodule // rdw_top_assertions
bind rdw_top rdw_top_assertions u_rdw_top_assertions (.*);
`default_nettype wire

// ===== tb/rdw_partner.sv
// supply detector and reset pin model
`default_nettype none
module rdw_partner (
	input wire logic aclk, // system clock
	input wire logic pullup_en, // weak pull-up active
	output logic power_good, // supply detector output
	output logic pin // reset pin wire level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drive_en = 1'b1;
	logic drive_val = 1'b0;
	logic last = 1'b0;
	initial power_good = 1'b0;
	always @(posedge aclk) if (drive_en) last <= drive_val;
	// undriven pin without pull-up shows a stale-inverse level, not a guess
	assign pin = drive_en ? drive_val : (pullup_en ? 1'b1 : ~last);
	task automatic supply(input logic v);
		@(posedge aclk);
		power_good <= v;
	endtask
	task automatic press(input logic drv, input logic v);
		@(posedge aclk);
		drive_en <= drv;
		drive_val <= v;
	endtask
endmodule // rdw_partner
`default_nettype wire

// ===== tb/reset_delay_and_watchdog_tb.sv
// self-checking bench for the reset delay and watchdog block
`default_nettype none
module reset_delay_and_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rdw_pkg::*;
	localparam int LONG = 40;
	localparam int POR = 20;
	localparam int BASE = 10;
	localparam int SHORT = RDW_DRT_SHORT_CYC;
	logic aclk;
	logic aresetn = 1'b0;
	logic clear_watchdog_instr = 1'b0;
	logic sleep_instr = 1'b0;
	logic pin_change_wake = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic s_axi_rready = 1'b1;
	logic power_good, external_reset_pin, core_reset, timeout_flag_n;
	logic powerdown_flag_n, reset_pin_pullup_en, irq, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, q;
	int miscompares = 0;
	int tests_run = 0;
	int n;
	rdw_partner u_rdw_partner (.aclk(aclk), .pullup_en(reset_pin_pullup_en),
		.power_good(power_good), .pin(external_reset_pin));
	rdw_top #(.DRT_LONG_CYC(LONG), .DRT_POR_CYC(POR), .WDT_BASE_CYC(BASE))
		u_rdw_top (.*);
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	// bready and rready stay high, so the answer edge is the handshake
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic [1:0] rs);
		int k;
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
		end
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (wr ? s_axi_bvalid : s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rs = wr ? s_axi_bresp : s_axi_rresp;
		if (k == 100) begin
			miscompares++;
			end_sim;
		end
	endtask
	// 0 clear watchdog, 1 sleep, 2 pin-change wake
	task automatic pulse(input int sel);
		if (sel == 0)
			clear_watchdog_instr <= 1'b1;
		else if (sel == 1)
			sleep_instr <= 1'b1;
		else
			pin_change_wake <= 1'b1;
		@(posedge aclk);
		clear_watchdog_instr <= 1'b0;
		sleep_instr <= 1'b0;
		pin_change_wake <= 1'b0;
	endtask
	task automatic wait_core(input logic v);
		for (n = 0; n < 3000 && core_reset !== v; n++) @(posedge aclk);
		if (n == 3000) begin
			miscompares++;
			end_sim;
		end
	endtask
	task automatic t_por;
		repeat (30) @(posedge aclk);
		chk(core_reset, 1);
		bus(0, RDW_OFS_CONFIG, 0, q, r);
		chk(q, RDW_CONFIG_RESET);
		// low lane strobe off: write answered but ignored
		s_axi_wstrb <= 4'h0;
		bus(1, RDW_OFS_CONFIG, 0, q, r);
		s_axi_wstrb <= 4'hf;
		chk(r, RDW_RESP_OKAY);
		bus(0, RDW_OFS_CONFIG, 0, q, r);
		chk(q, RDW_CONFIG_RESET);
		bus(0, RDW_OFS_OPTION, 0, q, r);
		chk(q, 0);
		bus(0, RDW_OFS_STATUS, 0, q, r);
		chk(q, 32'h19);
		bus(1, 8'h14, 0, q, r);
		chk(r, RDW_RESP_SLVERR);
		u_rdw_partner.supply(1);
		repeat (40) @(posedge aclk);
		chk(core_reset, 1);
		u_rdw_partner.press(1, 1);
		wait_core(0);
		chk(n >= POR && n <= POR + 8, 1);
	endtask
	task automatic t_modes;
		int e [4] = '{SHORT, SHORT, LONG, LONG};
		for (int m = 0; m < 4; m++) begin
			bus(1, RDW_OFS_CONFIG, {m[1:0], 2'b11}, q, r);
			u_rdw_partner.press(1, 0);
			repeat (10) @(posedge aclk);
			chk(core_reset, 1);
			u_rdw_partner.press(1, 1);
			wait_core(0);
			chk(n >= e[m] && n <= e[m] + 8, 1);
		end
	endtask
	task automatic t_wdog;
		logic [7:0] o [4] = '{8'h07, 8'h08, 8'h0a, 8'hff};
		int e [4] = '{BASE, BASE, 4 * BASE, 128 * BASE};
		for (int i = 0; i < 4; i++) begin
			bus(1, RDW_OFS_CONFIG, 32'h0f, q, r);
			bus(1, RDW_OFS_IRQ_MASK, i != 0, q, r);
			// free-running count must not wrap before the option lands
			pulse(0);
			bus(1, RDW_OFS_OPTION, o[i], q, r);
			pulse(0);
			wait_core(1);
			chk(n >= e[i] - 2 && n <= e[i] + 4, 1);
			repeat (3) @(posedge aclk);
			chk(timeout_flag_n, 0);
			chk(powerdown_flag_n, 1);
			chk(irq, i != 0);
			bus(0, RDW_OFS_IRQ_STATUS, 0, q, r);
			chk(q[RDW_EV_WDT], 1);
			bus(0, RDW_OFS_IRQ_STATUS, 0, q, r);
			repeat (2) @(posedge aclk);
			chk(irq, 0);
			wait_core(0);
		end
	endtask
	task automatic t_clear;
		bus(1, RDW_OFS_OPTION, 32'h08, q, r);
		repeat (10) begin
			pulse(0);
			repeat (6) @(posedge aclk);
		end
		chk({core_reset, timeout_flag_n}, 2'b01);
		bus(1, RDW_OFS_CONFIG, 32'h0e, q, r);
		repeat (300) @(posedge aclk);
		chk(core_reset, 0);
	endtask
	task automatic t_sleep;
		bus(1, RDW_OFS_CONFIG, 32'h0f, q, r);
		bus(1, RDW_OFS_OPTION, 32'h08, q, r);
		pulse(1);
		repeat (2) @(posedge aclk);
		chk({timeout_flag_n, powerdown_flag_n}, 2'b10);
		wait_core(1);
		chk(n >= BASE - 4 && n <= BASE + 4, 1);
		repeat (3) @(posedge aclk);
		chk({timeout_flag_n, powerdown_flag_n}, 2'b00);
		wait_core(0);
		chk(n >= LONG - 6 && n <= LONG + 4, 1);
		pulse(1);
		repeat (5) @(posedge aclk);
		pulse(2);
		repeat (3) @(posedge aclk);
		chk({core_reset, timeout_flag_n, powerdown_flag_n}, 3'b110);
		wait_core(0);
		// reset pin pulled low while asleep
		pulse(1);
		u_rdw_partner.press(1, 0);
		repeat (8) @(posedge aclk);
		chk({core_reset, timeout_flag_n, powerdown_flag_n}, 3'b110);
		u_rdw_partner.press(1, 1);
		wait_core(0);
	endtask
	task automatic t_pin;
		bus(1, RDW_OFS_CONFIG, 32'h0c, q, r);
		repeat (2) @(posedge aclk);
		chk(reset_pin_pullup_en, 1);
		u_rdw_partner.press(1, 0);
		repeat (30) @(posedge aclk);
		chk(core_reset, 0);
		u_rdw_partner.press(0, 0);
		@(posedge aclk);
		chk(external_reset_pin, 1);
		u_rdw_partner.press(1, 1);
		bus(1, RDW_OFS_CONFIG, 32'h0f, q, r);
		repeat (2) @(posedge aclk);
		chk(reset_pin_pullup_en, 0);
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_por;
		t_modes;
		t_wdog;
		t_clear;
		t_sleep;
		t_pin;
		end_sim;
	end
endmodule // reset_delay_and_watchdog_tb
`default_nettype wire
